// ==== src/dsw_pkg.sv ====
// package: constants for the deep sleep wake and retention controller
package dsw_pkg;
  // deep_sleep_control_reg bit positions
  localparam int CTL_ARM_BIT     = 15;
  localparam int CTL_BOR_BIT     = 1;
  localparam int CTL_RELEASE_BIT = 0;
  // reset_control_reg bit position of the deep_sleep_occurred_flag
  localparam int RESET_CONTROL_REG_DPS_BIT    = 10;
  // config_word_four field positions
  localparam int CW4_WDT_EN_BIT  = 7;
  localparam int CW4_CAL_SEL_BIT = 5;
  localparam int CW4_WDT_CLK_BIT = 4;
  localparam int CW4_PS_HI       = 3;
  localparam int CW4_PS_LO       = 0;
  // wake_source_reg bit positions
  localparam int WK_EXTERNAL_INTERRUPT_ZERO_BIT     = 8;
  localparam int WK_WDT_BIT      = 4;
  localparam int WK_CAL_BIT      = 3;
  localparam int WK_MASTER_CLEAR_PIN_BIT     = 2;
  localparam int WK_POR_BIT      = 0;
  // instruction cycles allowed between arming and the sleep instruction
  localparam logic [1:0] ARM_WINDOW = 2'h3;
  // watchdog postscale: timeout = slow ticks << (base + ps)
  localparam int WDT_BASE_SHIFT  = 6;
  localparam int WDT_CNT_W       = 38;
  // power-on reset sequence length in mclk cycles
  localparam int POR_SEQ_CYCLES  = 16;
  // controller states, one-hot
  typedef enum logic [3:0] {
    DSW_RUN   = 4'h1,
    DSW_SLEEP = 4'h2,
    DSW_EXIT  = 4'h4,
    DSW_HOLD  = 4'h8
  } dsw_state_t;
endpackage

// ==== src/dsw_watchdog.sv ====
// deep sleep watchdog counter with selectable clock and postscaler
`timescale 1ns/1ps
module dsw_watchdog #(
  parameter int CNT_W = dsw_pkg::WDT_CNT_W
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // control
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [3:0]       postscale,
  // status
  output logic                  timeout
);
  initial begin
    if (CNT_W < dsw_pkg::WDT_BASE_SHIFT + 16) $error("dsw_watchdog: CNT_W too small");
  end

  logic [CNT_W-1:0] count;
  wire  [CNT_W-1:0] limit = CNT_W'(1) << (dsw_pkg::WDT_BASE_SHIFT + int'(postscale));
  wire              hit   = run && tick && (count + CNT_W'(1) >= limit);

  // counter restarts on every entry so a stale count never wakes early
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      timeout <= 1'b0;
    end else if (clear) begin
      count   <= '0;
      timeout <= 1'b0;
    end else begin
      if (run && tick && !hit) count <= count + CNT_W'(1);
      timeout <= hit;
    end
  end
endmodule

// ==== src/dsw_ctrl.sv ====
// deep sleep wake, retention and pin hold controller
`timescale 1ns/1ps
// Summary of operation
// - calendar alarm wakes only if calendar enable was 1 at entry
// - master clear pin driven low wakes the device
// - external_interrupt_zero wakes if enabled at entry, on a change to configured level
// - watchdog timeout wakes the device
// - interrupts pending at entry are cleared
// - exit acts as power-on reset; calendar, watchdog, context survive
// - wake events during exit and reset sequence are ignored
// - on wake: reset, clear arm bit, restart at reset vector
// - deep sleep occurred flag set on exit; software clears it
// - brown-out during deep sleep reported in control bit 1
// - context save registers keep contents through deep sleep
// - pins and secondary oscillator hold entry state in deep sleep
// - after wake pins stay held while release bit is set
// - clearing release makes pins follow direction and latch
// - brown-out or true power-on releases pins, discards retained state
// - master clear keeps registers and hold; pins take reset state
// - watchdog enabled by config bit 7, reset on entry
// - watchdog clock from config bit 4, postscale bits 3 to 0
// - calendar clock chosen by config bit 5
// - watchdog clock source started automatically at entry
// - arm bit 15 set then sleep instruction enters deep sleep
// - arm bit cleared if sleep not within three instruction cycles
// - setting arm bit clears every wake source flag
module dsw_ctrl #(
  parameter int PIN_W   = 16,
  parameter int CTX_W   = 16,
  parameter int POR_CYC = dsw_pkg::POR_SEQ_CYCLES
) (
  // clock and reset (rst_n is the true supply power-on reset)
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // firmware strobes and writes
  input  wire logic             instr_cycle,
  input  wire logic             arm_set,
  input  wire logic             sleep_instr,
  input  wire logic             release_clear,
  input  wire logic             occurred_clear,
  input  wire logic             bor_flag_clear,
  input  wire logic             wake_flags_clear,
  input  wire logic             ctx_we0,
  input  wire logic             ctx_we1,
  input  wire logic [CTX_W-1:0] ctx_wdata,
  // configuration
  input  wire logic [7:0]       config_word_four,
  input  wire logic             calendar_enable,
  input  wire logic             external_interrupt_zero_enable,
  input  wire logic             external_interrupt_zero_polarity,
  input  wire logic             secondary_osc_enable,
  input  wire logic [PIN_W-1:0] pin_direction,
  input  wire logic [PIN_W-1:0] pin_output_latch,
  input  wire logic [PIN_W-1:0] master_clear_pin_pin_dir,
  input  wire logic [PIN_W-1:0] master_clear_pin_pin_level,
  // wake sources and slow clocks
  input  wire logic             master_clear_pin,
  input  wire logic             external_interrupt_zero,
  input  wire logic             calendar_alarm,
  input  wire logic             deep_sleep_brownout_evt,
  input  wire logic             low_power_rc_tick,
  input  wire logic             secondary_osc_tick,
  // status and control outputs
  output logic                  deep_sleep_arm,
  output logic                  deep_sleep_brownout,
  output logic                  pin_hold_release,
  output logic                  deep_sleep_occurred_flag,
  output logic [15:0]           wake_source_reg,
  output logic [CTX_W-1:0]      context_save_0,
  output logic [CTX_W-1:0]      context_save_1,
  output logic                  in_deep_sleep,
  output logic                  core_reset,
  output logic                  pending_irq_clear,
  output logic                  calendar_clk_sel,
  output logic                  low_power_rc_osc_force_on,
  output logic                  secondary_oscillator_force_on,
  output logic                  secondary_oscillator_run,
  // pads
  output logic [PIN_W-1:0]      pin_out,
  output logic [PIN_W-1:0]      pin_oe
);
  initial begin
    if (PIN_W < 1 || CTX_W < 1 || POR_CYC < 1) $error("dsw_ctrl: bad parameter");
  end

  localparam int PC_W = $clog2(POR_CYC + 1);

  dsw_pkg::dsw_state_t state;
  dsw_pkg::dsw_state_t next_state;
  logic [1:0]       arm_age;
  logic [PC_W-1:0]  por_cnt;
  logic             external_interrupt_zero_q;
  logic             cal_en_lat;
  logic             external_interrupt_zero_en_lat;
  logic             external_interrupt_zero_pol_lat;
  logic             wdt_en_lat;
  logic             wdt_clk_lat;
  logic             secondary_oscillator_hold;
  logic [PIN_W-1:0] held_out;
  logic [PIN_W-1:0] held_oe;
  logic             master_clear_pin_reset;
  logic             wdt_timeout;

  // configuration fields
  wire       cfg_wdt_en  = config_word_four[dsw_pkg::CW4_WDT_EN_BIT];
  wire       cfg_wdt_clk = config_word_four[dsw_pkg::CW4_WDT_CLK_BIT];
  wire [3:0] cfg_ps = config_word_four[dsw_pkg::CW4_PS_HI:dsw_pkg::CW4_PS_LO];

  // wake qualification; inputs treated as synchronous to mclk
  wire asleep   = (state == dsw_pkg::DSW_SLEEP);
  wire enter    = (state == dsw_pkg::DSW_RUN) && deep_sleep_arm && sleep_instr;
  // arming counts only in run and never on the entry edge; only then, or on wake_flags_clear, are wake flags wiped
  wire arm_take = arm_set && (state == dsw_pkg::DSW_RUN) && !enter;
  wire w_master_clear_pin   = asleep && !master_clear_pin;
  wire w_cal    = asleep && cal_en_lat && calendar_alarm;
  wire external_interrupt_zero_act = (external_interrupt_zero == external_interrupt_zero_pol_lat);
  wire external_interrupt_zero_chg = (external_interrupt_zero != external_interrupt_zero_q);
  wire w_external_interrupt_zero   = asleep && external_interrupt_zero_en_lat && external_interrupt_zero_chg && external_interrupt_zero_act;
  wire w_wdt    = asleep && wdt_timeout;
  wire wake_any = w_master_clear_pin | w_cal | w_external_interrupt_zero | w_wdt;
  wire arm_late = (arm_age == dsw_pkg::ARM_WINDOW) && instr_cycle && !sleep_instr;
  wire por_done = (por_cnt == PC_W'(POR_CYC));
  wire slow_tick = wdt_clk_lat ? secondary_osc_tick : low_power_rc_tick;

  dsw_watchdog u_wdt (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clear     (enter),
    .run       (asleep && wdt_en_lat),
    .tick      (slow_tick),
    .postscale (cfg_ps),
    .timeout   (wdt_timeout)
  );

  // state sequencing: run, deep sleep, power-on exit, then pin hold
  always_comb begin
    next_state = state;
    case (state)
      dsw_pkg::DSW_RUN: begin
        if (enter) next_state = dsw_pkg::DSW_SLEEP;
      end
      dsw_pkg::DSW_SLEEP: begin
        if (wake_any) next_state = dsw_pkg::DSW_EXIT;
      end
      dsw_pkg::DSW_EXIT: begin
        if (por_done) next_state = dsw_pkg::DSW_HOLD;
      end
      dsw_pkg::DSW_HOLD: begin
        if (!pin_hold_release) next_state = dsw_pkg::DSW_RUN;
      end
      default: next_state = dsw_pkg::DSW_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) state <= dsw_pkg::DSW_RUN;
    else        state <= next_state;
  end

  // arm bit with the three-instruction entry window
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep_arm <= 1'b0;
      arm_age        <= 2'h0;
    end else if (enter || wake_any) begin
      deep_sleep_arm <= 1'b0;
      arm_age        <= 2'h0;
    end else if (arm_take) begin
      deep_sleep_arm <= 1'b1;
      arm_age        <= 2'h0;
    end else if (arm_late) begin
      deep_sleep_arm <= 1'b0;
      arm_age        <= 2'h0;
    end else if (deep_sleep_arm && instr_cycle) begin
      arm_age        <= arm_age + 2'h1;
    end
  end

  // settings latched at entry; the watchdog oscillator is forced on if off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_en_lat   <= 1'b0;
      external_interrupt_zero_en_lat  <= 1'b0;
      external_interrupt_zero_pol_lat <= 1'b0;
      wdt_en_lat   <= 1'b0;
      wdt_clk_lat  <= 1'b0;
      external_interrupt_zero_q       <= 1'b0;
    end else begin
      external_interrupt_zero_q <= external_interrupt_zero;
      if (enter) begin
        cal_en_lat   <= calendar_enable;
        external_interrupt_zero_en_lat  <= external_interrupt_zero_enable;
        external_interrupt_zero_pol_lat <= external_interrupt_zero_polarity;
        wdt_en_lat   <= cfg_wdt_en;
        wdt_clk_lat  <= cfg_wdt_clk;
      end
    end
  end

  // wake flags: only set in deep sleep, cleared on arming; set wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_source_reg <= 16'h0001;                                             // true power-on
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (arm_take || wake_flags_clear) wake_source_reg[i] <= 1'b0;
      end
      if (w_external_interrupt_zero) wake_source_reg[dsw_pkg::WK_EXTERNAL_INTERRUPT_ZERO_BIT] <= 1'b1;
      if (w_wdt)  wake_source_reg[dsw_pkg::WK_WDT_BIT]  <= 1'b1;
      if (w_cal)  wake_source_reg[dsw_pkg::WK_CAL_BIT]  <= 1'b1;
      if (w_master_clear_pin) wake_source_reg[dsw_pkg::WK_MASTER_CLEAR_PIN_BIT] <= 1'b1;
    end
  end

  // occurred, brown-out and release flags; hardware set beats software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep_occurred_flag <= 1'b0;
      deep_sleep_brownout      <= 1'b0;
      pin_hold_release         <= 1'b0;
      master_clear_pin_reset               <= 1'b0;
    end else begin
      if (wake_any) deep_sleep_occurred_flag <= 1'b1;
      else if (occurred_clear) deep_sleep_occurred_flag <= 1'b0;
      if (asleep && deep_sleep_brownout_evt) deep_sleep_brownout <= 1'b1;
      else if (bor_flag_clear) deep_sleep_brownout <= 1'b0;
      if (asleep && deep_sleep_brownout_evt) pin_hold_release <= 1'b0;
      else if (enter) pin_hold_release <= 1'b1;
      else if (release_clear && state != dsw_pkg::DSW_EXIT) pin_hold_release <= 1'b0;
      if (w_master_clear_pin) master_clear_pin_reset <= 1'b1;
      else if (!pin_hold_release) master_clear_pin_reset <= 1'b0;
    end
  end

  // context save registers, wiped by a deep-sleep brown-out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      context_save_0 <= '0;
      context_save_1 <= '0;
    end else if (asleep && deep_sleep_brownout_evt) begin
      context_save_0 <= '0;
      context_save_1 <= '0;
    end else if (state == dsw_pkg::DSW_RUN) begin
      if (ctx_we0) context_save_0 <= ctx_wdata;
      if (ctx_we1) context_save_1 <= ctx_wdata;
    end
  end

  // pin capture at entry and pin drive selection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      held_out  <= '0;
      held_oe   <= '0;
      secondary_oscillator_hold <= 1'b0;
    end else if (enter) begin
      held_out  <= pin_output_latch;
      held_oe   <= ~pin_direction;
      secondary_oscillator_hold <= secondary_osc_enable;
    end
  end

  // pin drive source; a brown-out lets go of the pins in the very cycle it is seen
  wire held  = pin_hold_release && !(asleep && deep_sleep_brownout_evt);
  wire [PIN_W-1:0] next_pin_out =
    !held ? pin_output_latch : (master_clear_pin_reset ? master_clear_pin_pin_level : held_out);
  wire [PIN_W-1:0] next_pin_oe =
    !held ? ~pin_direction : (master_clear_pin_reset ? ~master_clear_pin_pin_dir : held_oe);
  wire next_secondary_oscillator = held ? secondary_oscillator_hold : secondary_osc_enable;

  // registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out           <= '0;
      pin_oe            <= '0;
      secondary_oscillator_run          <= 1'b0;
      in_deep_sleep     <= 1'b0;
      core_reset        <= 1'b1;
      pending_irq_clear <= 1'b0;
      calendar_clk_sel  <= 1'b0;
      low_power_rc_osc_force_on     <= 1'b0;
      secondary_oscillator_force_on     <= 1'b0;
      por_cnt           <= '0;
    end else begin
      pin_out           <= next_pin_out;
      pin_oe            <= next_pin_oe;
      secondary_oscillator_run          <= next_secondary_oscillator;
      in_deep_sleep     <= (next_state == dsw_pkg::DSW_SLEEP);
      core_reset        <= (next_state == dsw_pkg::DSW_SLEEP)
                        || (next_state == dsw_pkg::DSW_EXIT);
      pending_irq_clear <= enter;
      calendar_clk_sel  <= config_word_four[dsw_pkg::CW4_CAL_SEL_BIT];
      low_power_rc_osc_force_on     <= (next_state == dsw_pkg::DSW_SLEEP) && wdt_en_lat && !wdt_clk_lat;
      secondary_oscillator_force_on     <= (next_state == dsw_pkg::DSW_SLEEP) && wdt_en_lat && wdt_clk_lat;
      if (state == dsw_pkg::DSW_EXIT && !por_done) por_cnt <= por_cnt + PC_W'(1);
      else if (state != dsw_pkg::DSW_EXIT) por_cnt <= '0;
    end
  end
endmodule

// ==== tb/dsw_osc_model.sv ====
// slow oscillator model giving tick pulses to the controller
`timescale 1ns/1ps
module dsw_osc_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // oscillator run requests
  input  wire logic low_power_rc_osc_on,
  input  wire logic secondary_oscillator_on,
  // tick pulses, one mclk cycle each
  output logic      low_power_rc_osc_tick,
  output logic      secondary_oscillator_tick
);
  logic [1:0] div;
  // a tick every fourth cycle; a stopped oscillator sends none, so a lost request hangs the wdt
  always_ff @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div       <= 2'h0;
      low_power_rc_osc_tick <= 1'b0;
      secondary_oscillator_tick <= 1'b0;
    end else begin
      div       <= div + 2'h1;
      low_power_rc_osc_tick <= low_power_rc_osc_on && div == 2'h3;
      secondary_oscillator_tick <= secondary_oscillator_on && div == 2'h3;
    end
  end
endmodule

// ==== tb/dsw_checker.sv ====
// checker: timing relations at the deep sleep controller ports
`timescale 1ns/1ps
module dsw_checker #(
  parameter int PIN_W = 16
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst_n,
  // inputs seen
  input wire logic             instr_cycle,
  input wire logic             master_clear_pin,
  input wire logic [PIN_W-1:0] pin_direction,
  input wire logic [PIN_W-1:0] pin_output_latch,
  // outputs watched
  input wire logic             deep_sleep_arm,
  input wire logic             deep_sleep_brownout,
  input wire logic             pin_hold_release,
  input wire logic [15:0]      wake_source_reg,
  input wire logic             in_deep_sleep,
  input wire logic             core_reset,
  input wire logic             pending_irq_clear,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [2:0] armed_cyc;
  // instruction cycles seen while armed; restarts whenever the arm drops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) armed_cyc <= 3'h0;
    else if (!deep_sleep_arm) armed_cyc <= 3'h0;
    else if (instr_cycle) armed_cyc <= armed_cyc + 3'h1;
  end
  a_arm_clears_flags: assert property (
    $rose(deep_sleep_arm) |-> wake_source_reg == 16'h0000) else $error("arm kept wake flags");
  a_arm_window_end: assert property (
    deep_sleep_arm |-> armed_cyc <= 3'h3) else $error("arm outlived its window");
  a_entry_effects: assert property (
    $rose(in_deep_sleep) |-> pending_irq_clear && !deep_sleep_arm && pin_hold_release)
    else $error("entry effects missing");
  a_irq_clear_once: assert property (
    pending_irq_clear |=> !pending_irq_clear) else $error("irq clear longer than a cycle");
  a_master_clear_pin_wakes: assert property (
    in_deep_sleep && !master_clear_pin |=> !in_deep_sleep && wake_source_reg[2])
    else $error("master clear did not wake");
  a_no_late_flags: assert property (
    (wake_source_reg & ~$past(wake_source_reg)) != 16'h0000 |-> $past(in_deep_sleep))
    else $error("wake flag set outside deep sleep");
  a_por_sequence: assert property (
    $fell(in_deep_sleep) |-> core_reset[*4] ##[1:40] !core_reset)
    else $error("reset sequence length wrong");
  a_pins_frozen: assert property (
    in_deep_sleep && $past(in_deep_sleep) && !deep_sleep_brownout
    |-> $stable(pin_oe) && $stable(pin_out & pin_oe)) else $error("pins moved in deep sleep");
  a_release_follow: assert property (
    $fell(pin_hold_release) && !core_reset |-> ##2 (pin_oe == ~pin_direction
    && (pin_out & pin_oe) == (pin_output_latch & pin_oe))) else $error("pins not released");
  c_entry: cover property ($rose(in_deep_sleep));
  c_wake: cover property ($fell(in_deep_sleep));
  c_release: cover property ($fell(pin_hold_release));
endmodule

bind dsw_ctrl dsw_checker #(.PIN_W(PIN_W)) dsw_checker_i (
  .mclk(mclk), .rst_n(rst_n), .instr_cycle(instr_cycle), .master_clear_pin(master_clear_pin),
  .pin_direction(pin_direction), .pin_output_latch(pin_output_latch),
  .deep_sleep_arm(deep_sleep_arm), .deep_sleep_brownout(deep_sleep_brownout),
  .pin_hold_release(pin_hold_release), .wake_source_reg(wake_source_reg),
  .in_deep_sleep(in_deep_sleep), .core_reset(core_reset),
  .pending_irq_clear(pending_irq_clear), .pin_out(pin_out), .pin_oe(pin_oe));

// ==== tb/tb_dsw_ctrl.sv ====
// testbench: deep sleep entry, wake sources, retention and pin hold
`timescale 1ns/1ps
module tb_dsw_ctrl;
  localparam int IC = 0, ARM = 1, SLP = 2, REL = 3, OCC = 4, BORC = 5, WFC = 6, WE0 = 7, WE1 = 8;
  localparam logic [15:0] DIR = 16'h00FF;
  logic        mclk = 1'b0, rst_n = 1'b0;
  logic [8:0]  stb = 9'h000;
  logic [15:0] ctx_wdata = 16'h0000, pin_direction = DIR, pin_output_latch = 16'hA5C3;
  logic [15:0] master_clear_pin_pin_dir = 16'h0F0F, master_clear_pin_pin_level = 16'h3333, lat0, exp_force;
  logic [7:0]  config_word_four = 8'h00;
  logic        calendar_enable = 1'b0, external_interrupt_zero_enable = 1'b0, external_interrupt_zero_polarity = 1'b1;
  logic        secondary_osc_enable = 1'b0, master_clear_pin = 1'b1, calendar_alarm = 1'b0;
  logic        external_interrupt_zero = 1'b0, deep_sleep_brownout_evt = 1'b0;
  logic        low_power_rc_tick, secondary_osc_tick, deep_sleep_arm, deep_sleep_brownout;
  logic        pin_hold_release, deep_sleep_occurred_flag, in_deep_sleep, core_reset;
  logic        pending_irq_clear, calendar_clk_sel, low_power_rc_osc_force_on, secondary_oscillator_force_on, secondary_oscillator_run;
  logic [15:0] wake_source_reg, context_save_0, context_save_1, pin_out, pin_oe;
  logic [15:0] exp_wake [6] = '{16'h0004, 16'h0100, 16'h0008, 16'h0010, 16'h0010, 16'h0100};
  logic [7:0]  cfg_k [6] = '{8'h00, 8'h00, 8'h20, 8'h80, 8'h91, 8'h00};
  int          fails = 0, cmp_count = 0;

  always #12.5 mclk = ~mclk;

  dsw_ctrl #(.POR_CYC(4)) dsw_ctrl_i (
    .mclk, .rst_n, .instr_cycle(stb[IC]), .arm_set(stb[ARM]), .sleep_instr(stb[SLP]),
    .release_clear(stb[REL]), .occurred_clear(stb[OCC]), .bor_flag_clear(stb[BORC]),
    .wake_flags_clear(stb[WFC]), .ctx_we0(stb[WE0]), .ctx_we1(stb[WE1]), .ctx_wdata,
    .config_word_four, .calendar_enable, .external_interrupt_zero_enable, .external_interrupt_zero_polarity, .secondary_osc_enable,
    .pin_direction, .pin_output_latch, .master_clear_pin_pin_dir, .master_clear_pin_pin_level, .master_clear_pin,
    .external_interrupt_zero, .calendar_alarm, .deep_sleep_brownout_evt, .low_power_rc_tick,
    .secondary_osc_tick, .deep_sleep_arm, .deep_sleep_brownout, .pin_hold_release,
    .deep_sleep_occurred_flag, .wake_source_reg, .context_save_0, .context_save_1,
    .in_deep_sleep, .core_reset, .pending_irq_clear, .calendar_clk_sel, .low_power_rc_osc_force_on,
    .secondary_oscillator_force_on, .secondary_oscillator_run, .pin_out, .pin_oe);
  dsw_osc_model dsw_osc_model_i (.mclk, .rst_n, .low_power_rc_osc_on(low_power_rc_osc_force_on),
    .secondary_oscillator_on(secondary_oscillator_run | secondary_oscillator_force_on), .low_power_rc_osc_tick(low_power_rc_tick),
    .secondary_oscillator_tick(secondary_osc_tick));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one-cycle strobe launched and dropped on falling edges
  task automatic pulse(input int b);
    @(negedge mclk);
    stb[b] = 1'b1;
    @(negedge mclk);
    stb = 9'h000;
  endtask
  task automatic pins(input logic [15:0] oe, input logic [15:0] out);
    chk(pin_oe, oe);
    chk(pin_out & oe, out & oe);
  endtask
  task automatic enter();
    pulse(ARM);
    chk(wake_source_reg, 16'h0000);
    pulse(SLP);
    tick(1);
    chk(16'(in_deep_sleep), 16'h0001);
    chk(16'(deep_sleep_arm), 16'h0000);
  endtask
  // bounded wait: a wake that never comes shows up as core_reset still high
  task automatic wait_up();
    int n;
    n = 0;
    while ((in_deep_sleep !== 1'b0 || core_reset !== 1'b0) && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(core_reset), 16'h0000);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    tick(20000);
    fails++;
    print_verdict();
  end

  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(2);
    chk(wake_source_reg, 16'h0001);
    chk(16'(pin_hold_release), 16'h0000);
    pins(~DIR, 16'hA5C3);
    pulse(ARM);
    chk(wake_source_reg, 16'h0000);
    repeat (3) pulse(IC);
    chk(16'(deep_sleep_arm), 16'h0001);
    pulse(IC);
    chk(16'(deep_sleep_arm), 16'h0000);
    pulse(SLP);
    chk(16'(in_deep_sleep), 16'h0000);
    $display("test arm window done");
    for (int k = 0; k < 6; k++) begin
      lat0 = k[0] ? 16'h5A3C : 16'hA5C3;
      external_interrupt_zero_enable = (k == 1) || (k == 5);
      external_interrupt_zero_polarity = (k != 5);
      external_interrupt_zero = (k == 5);
      calendar_enable = (k == 2);
      config_word_four = cfg_k[k];
      pin_output_latch = lat0;
      ctx_wdata = 16'h1100 + 16'(k);
      pulse(WE0);
      ctx_wdata = 16'h2200 + 16'(k);
      pulse(WE1);
      enter();
      chk(16'(calendar_clk_sel), 16'(config_word_four[5]));
      exp_force = (k == 3) ? 16'h0001 : ((k == 4) ? 16'h0002 : 16'h0000);
      chk({14'h0000, secondary_oscillator_force_on, low_power_rc_osc_force_on}, exp_force);
      pin_output_latch = ~lat0;
      if (k == 0) begin
        calendar_alarm = 1'b1;
        external_interrupt_zero = 1'b1;
        tick(10);
        chk(16'(in_deep_sleep), 16'h0001);
        calendar_alarm = 1'b0;
        external_interrupt_zero = 1'b0;
      end
      pins(~DIR, lat0);
      case (k)
        0: master_clear_pin = 1'b0;
        1: external_interrupt_zero = 1'b1;
        2: calendar_alarm = 1'b1;
        4: begin
          tick(300);
          chk(16'(in_deep_sleep), 16'h0001);
        end
        5: external_interrupt_zero = 1'b0;
        default: ;
      endcase
      tick(3);
      master_clear_pin = 1'b1;
      wait_up();
      external_interrupt_zero = 1'b0;
      calendar_alarm = 1'b0;
      chk(wake_source_reg, exp_wake[k]);
      chk(16'(deep_sleep_occurred_flag), 16'h0001);
      chk(16'(pin_hold_release), 16'h0001);
      chk(context_save_0, 16'h1100 + 16'(k));
      chk(context_save_1, 16'h2200 + 16'(k));
      if (k == 0) pins(~master_clear_pin_pin_dir, master_clear_pin_pin_level);
      else pins(~DIR, lat0);
      pulse(OCC);
      chk(16'(deep_sleep_occurred_flag), 16'h0000);
      secondary_osc_enable = 1'b1;
      pulse(REL);
      tick(2);
      pins(~DIR, ~lat0);
      chk(16'(secondary_oscillator_run), 16'h0001);
      secondary_osc_enable = 1'b0;
      tick(2);
      $display("test wake source %0d done", k);
    end
    // brown-out while asleep only flags, lets the pins go and drops the context
    ctx_wdata = 16'h7E57;
    pulse(WE0);
    enter();
    pin_output_latch = 16'hC3A5;
    deep_sleep_brownout_evt = 1'b1;
    tick(1);
    deep_sleep_brownout_evt = 1'b0;
    tick(3);
    chk(16'(deep_sleep_brownout), 16'h0001);
    chk(16'(in_deep_sleep), 16'h0001);
    chk(context_save_0, 16'h0000);
    chk(context_save_1, 16'h0000);
    pins(~DIR, 16'hC3A5);
    master_clear_pin = 1'b0;
    tick(3);
    master_clear_pin = 1'b1;
    wait_up();
    chk(16'(deep_sleep_brownout), 16'h0001);
    pulse(BORC);
    chk(16'(deep_sleep_brownout), 16'h0000);
    pulse(REL);
    pulse(WFC);
    chk(wake_source_reg, 16'h0000);
    $display("test brown-out done");
    print_verdict();
  end
endmodule
